/* File: hw/mpss_consts.svh */
`ifndef MPSS_CONSTS_SVH
`define MPSS_CONSTS_SVH

// core clock period in ns (20 MHz)
`define MPSS_CLK_NS 50
// least-time conversion from ns to core cycles, rounded up
`define MPSS_CYC_UP(ns) (((ns) + `MPSS_CLK_NS - 1) / `MPSS_CLK_NS)

// master switching clock period, in ns, and in core cycles
`define MPSS_MCLK_NS 1000
`define MPSS_MCLK_CYC (`MPSS_MCLK_NS / `MPSS_CLK_NS)
// master clock ticks spent on phase detection
`define MPSS_DETECT_TICKS 4

// first delay-timer cycle after enable and supply release
`define MPSS_TD1_NS 100000
`define MPSS_TD1_CYC `MPSS_CYC_UP(`MPSS_TD1_NS)
// time per one-code step of the soft-start ramp
`define MPSS_SS_STEP_NS 5000
`define MPSS_SS_STEP_CYC `MPSS_CYC_UP(`MPSS_SS_STEP_NS)
// power-good masking time after the ramp reaches its target
`define MPSS_MASK_NS 50000
`define MPSS_MASK_CYC `MPSS_CYC_UP(`MPSS_MASK_NS)
// second delay-timer ramp, the power-good blanking interval
`define MPSS_TD3_NS 100000
`define MPSS_TD3_CYC `MPSS_CYC_UP(`MPSS_TD3_NS)

`endif

/* File: hw/mpss_phase_slice.sv */
`timescale 1ns/1ns
// one phase: the pulse starts on its trigger and ends after the on-time
module mpss_phase_slice
  import mpss_pkg::*;
(
  input  wire logic         core_clk,
  input  wire logic         rstn,
  input  wire logic         run,
  input  wire logic         start,
  input  wire mpss_ontime_t ontime,
  output logic              drive
);

  logic [7:0] cnt;       // cycles since this phase was last triggered
  logic [7:0] next_cnt;
  logic       next_drive;

  // saturating count, so an on-time longer than the period stays high
  always_comb begin
    next_cnt = cnt;
    if (!run) begin
      next_cnt = 8'hff;
    end else if (start) begin
      next_cnt = 8'h00;
    end else if (cnt != 8'hff) begin
      next_cnt = cnt + 8'h01;
    end
    // each phase judged on its own, so duty may approach full on
    next_drive = run && (next_cnt < ontime);
  end

  // registers only
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt   <= 8'hff;
      drive <= 1'b0;
    end else begin
      cnt   <= next_cnt;
      drive <= next_drive;
    end
  end

endmodule

/* File: hw/mpss_pkg.sv */
package mpss_pkg;

  // start-up sequencer states, in order of progress
  typedef enum logic [2:0] {
    ST_OFF    = 3'b000,
    ST_DELAY1 = 3'b001,
    ST_DETECT = 3'b010,
    ST_SOFTST = 3'b011,
    ST_MASK   = 3'b100,
    ST_BLANK  = 3'b101,
    ST_RUN    = 3'b110
  } mpss_state_t;

  // on-time of one phase, in core cycles
  typedef logic [7:0] mpss_ontime_t;

  // everything the block drives onto the four phase pins
  typedef struct packed {
    logic phase_a_drive;
    logic phase_b_drive;
    logic phase_c_drive;
    logic phase_d_drive;
    logic phase_c_oe;    // high while the block drives phase c
    logic phase_d_oe;    // high while the block drives phase d
    logic phase_c_sink;  // weak pull-down on phase c
    logic phase_d_sink;  // weak pull-down on phase d
  } mpss_pins_t;

endpackage

/* File: hw/mpss_top.sv */
`timescale 1ns/1ns
`include "mpss_consts.svh"
module mpss_top
  import mpss_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rstn,
  input  wire logic              enable,
  input  wire logic              supply_undervoltage_lockout,
  input  wire logic [5:0]        vid_code,
  input  wire mpss_ontime_t [3:0] ontime,
  input  wire logic              phase_c_sense,
  input  wire logic              phase_d_sense,
  output mpss_pins_t             pins,
  output logic                   power_good_out,
  output logic [5:0]             ss_ramp_level
);

  mpss_state_t st;        // sequencer state
  mpss_state_t next_st;
  logic [11:0] tmr;       // shared interval timer
  logic [11:0] next_tmr;
  logic [5:0]  next_ss;   // soft-start ramp level
  logic [1:0]  det;       // detection ticks seen
  logic [1:0]  next_det;
  logic        strap_c;   // phase c found tied to supply
  logic        strap_d;   // phase d found tied to supply
  logic        next_strap_c;
  logic        next_strap_d;
  logic        go;        // enable high and supply out of lockout
  logic        mtick;     // last core cycle of a master clock period

  logic [4:0]  mcnt;      // master clock divider
  logic [4:0]  next_mcnt;
  logic [1:0]  rot;       // phase to trigger on the next tick
  logic [1:0]  next_rot;
  logic [3:0]  active;    // phases in use, bit 0 is phase a
  logic        sw_on;     // switching allowed in this state
  logic [3:0]  start;     // one-cycle trigger per phase
  logic [3:0]  drv;       // slice outputs
  mpss_pins_t  next_pins;
  logic [3:0]  pin_ctl;   // registered c/d oe then c/d sink
  logic        next_pg;

  // pick the next phase in use after cur, wrapping round
  function automatic logic [1:0] mpss_next_active(
    input logic [1:0] cur,
    input logic [3:0] mask
  );
    logic [1:0] cand;
    logic [1:0] res;
    res = cur;
    for (int i = 3; i >= 1; i--) begin
      cand = cur + 2'(i);
      if (mask[cand]) begin
        res = cand;
      end
    end
    return res;
  endfunction

  assign go     = enable && !supply_undervoltage_lockout;
  assign mtick  = (mcnt == 5'(`MPSS_MCLK_CYC - 1));
  // a strapped pin drops out of the set of phases
  assign active = {!strap_d, !strap_c, 2'b11};
  // no pulses before the ramp, so detection ticks stay quiet
  assign sw_on  = (st >= ST_SOFTST) && (st <= ST_RUN);

  // sequencer: delay, detect, ramp, masking, blanking, run
  always_comb begin
    next_st      = st;
    next_tmr     = tmr;
    next_ss      = ss_ramp_level;
    next_det     = det;
    next_strap_c = strap_c;
    next_strap_d = strap_d;
    case (st)
      ST_OFF: begin
        next_st  = ST_DELAY1;
        next_tmr = 12'h000;
      end
      ST_DELAY1: begin
        // exactly one delay interval before anything else
        if (tmr == 12'(`MPSS_TD1_CYC - 1)) begin
          next_st  = ST_DETECT;
          next_tmr = 12'h000;
        end else begin
          next_tmr = tmr + 12'h001;
        end
      end
      ST_DETECT: begin
        if (mtick) begin
          next_det = det + 2'h1;
          if (det == 2'(`MPSS_DETECT_TICKS - 1)) begin
            // sense is taken once, at the end of the window
            next_strap_c = phase_c_sense;
            next_strap_d = phase_d_sense;
            next_st      = ST_SOFTST;
          end
        end
      end
      ST_SOFTST, ST_MASK, ST_BLANK, ST_RUN: begin
        next_tmr = tmr + 12'h001;
        if (st == ST_SOFTST && ss_ramp_level == vid_code) begin
          next_st  = ST_MASK;
          next_tmr = 12'h000;
        end else if (st == ST_MASK &&
                     tmr == 12'(`MPSS_MASK_CYC - 1)) begin
          next_st  = ST_BLANK;
          next_tmr = 12'h000;
        end else if (st == ST_BLANK &&
                     tmr == 12'(`MPSS_TD3_CYC - 1)) begin
          next_st  = ST_RUN;
          next_tmr = 12'h000;
        end
        // ramp steps toward the code; later code changes slew too
        if (tmr >= 12'(`MPSS_SS_STEP_CYC - 1) &&
            ss_ramp_level != vid_code) begin
          next_ss = (ss_ramp_level < vid_code) ? ss_ramp_level + 6'h01
                                               : ss_ramp_level - 6'h01;
          if (st == ST_SOFTST || st == ST_RUN) begin
            next_tmr = 12'h000;
          end
        end
        if (st == ST_RUN && tmr == 12'hfff) begin
          next_tmr = tmr;  // hold rather than wrap
        end
      end
      default: begin
        next_st = ST_OFF;
      end
    endcase
    // losing enable or supply wipes every interval
    if (!go) begin
      next_st      = ST_OFF;
      next_tmr     = 12'h000;
      next_ss      = 6'h00;
      next_det     = 2'h0;
      next_strap_c = 1'b0;
      next_strap_d = 1'b0;
    end
  end

  // sequencer registers
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st            <= ST_OFF;
      tmr           <= 12'h000;
      ss_ramp_level <= 6'h00;
      det           <= 2'h0;
      strap_c       <= 1'b0;
      strap_d       <= 1'b0;
    end else begin
      st            <= next_st;
      tmr           <= next_tmr;
      ss_ramp_level <= next_ss;
      det           <= next_det;
      strap_c       <= next_strap_c;
      strap_d       <= next_strap_d;
    end
  end

  // master clock and phase rotation
  always_comb begin
    next_mcnt = mtick ? 5'h00 : mcnt + 5'h01;
    next_rot  = rot;
    // divider restarts so detection gets four whole periods
    if (!go || st == ST_DELAY1) begin
      next_mcnt = 5'h00;
    end
    if (!sw_on) begin
      next_rot = 2'h0;
    end else if (mtick) begin
      // one active phase per tick: rate is master over count
      next_rot = mpss_next_active(rot, active);
    end
    start = 4'h0;
    if (sw_on && mtick) begin
      start[rot] = 1'b1;
    end
  end

  // divider registers
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      mcnt <= 5'h00;
      rot  <= 2'h0;
    end else begin
      mcnt <= next_mcnt;
      rot  <= next_rot;
    end
  end

  // independent slices, so pulses of different phases may overlap
  for (genvar g = 0; g < 4; g++) begin : g_phase
    mpss_phase_slice u_slice (
      .core_clk (core_clk),
      .rstn     (rstn),
      .run      (sw_on && active[g] && go),
      .start    (start[g]),
      .ontime   (ontime[g]),
      .drive    (drv[g])
    );
  end

  // pin controls follow the state being entered
  always_comb begin
    next_pins = '0;
    // weak sink and sense from power-off until the ramp
    next_pins.phase_c_sink = (next_st <= ST_DETECT);
    next_pins.phase_d_sink = (next_st <= ST_DETECT);
    // unstrapped pins switch, strapped ones float
    next_pins.phase_c_oe = (next_st >= ST_SOFTST) && !next_strap_c;
    next_pins.phase_d_oe = (next_st >= ST_SOFTST) && !next_strap_d;
    // the sink doubles as a drive-low while detecting
    next_pins.phase_c_drive = 1'b0;
    next_pins.phase_d_drive = 1'b0;
    next_pg = (next_st == ST_RUN);
  end

  // pin control registers; slice drives are already flops
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pin_ctl        <= 4'h3;
      power_good_out <= 1'b0;
    end else begin
      pin_ctl        <= {next_pins.phase_c_oe, next_pins.phase_d_oe,
                         next_pins.phase_c_sink, next_pins.phase_d_sink};
      power_good_out <= next_pg;
    end
  end

  // one driver for the whole pin struct, so no field has two sources;
  // a and b are low in detection because their slices are idle
  assign pins = {drv[0], drv[1], drv[2], drv[3], pin_ctl};

  // helper: core cycles between two triggers of phase a
  logic [7:0] since_a;
  logic       seen_a;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      since_a <= 8'h00;
      seen_a  <= 1'b0;
    end else begin
      since_a <= start[0] ? 8'h01 : since_a + 8'h01;
      seen_a  <= sw_on && (seen_a || start[0]);
    end
  end

  property p_delay_first;
    @(posedge core_clk) disable iff (!rstn)
    (st == ST_OFF && go) |=> st == ST_DELAY1 ##1 st == ST_DELAY1;
  endproperty
  a_delay_first: assert property (p_delay_first)
    else $error("delay interval not started first");

  property p_detect_quiet;
    @(posedge core_clk) disable iff (!rstn)
    (st == ST_DETECT) |-> (drv == 4'h0);
  endproperty
  a_detect_quiet: assert property (p_detect_quiet)
    else $error("pulse seen during phase detection");

  property p_ramp_start;
    @(posedge core_clk) disable iff (!rstn)
    (st == ST_DETECT && mtick && det == 2'h3 && go)
      |=> (st == ST_SOFTST && ss_ramp_level == 6'h00);
  endproperty
  a_ramp_start: assert property (p_ramp_start)
    else $error("soft start did not follow detection");

  property p_blank_after_mask;
    @(posedge core_clk) disable iff (!rstn)
    (st == ST_MASK && go && tmr == 12'(`MPSS_MASK_CYC - 1))
      |=> st == ST_BLANK && !power_good_out;
  endproperty
  a_blank_after_mask: assert property (p_blank_after_mask)
    else $error("blanking did not follow masking");

  property p_sink_early;
    @(posedge core_clk) disable iff (!rstn)
    (st == ST_OFF) |=> (pins.phase_c_sink && pins.phase_d_sink &&
                        !pins.phase_c_oe && !pins.phase_d_oe);
  endproperty
  a_sink_early: assert property (p_sink_early)
    else $error("weak sink missing before soft start");

  property p_float_strapped;
    @(posedge core_clk) disable iff (!rstn)
    (st == ST_RUN && strap_d) |-> (!pins.phase_d_oe &&
      !pins.phase_d_sink && !pins.phase_d_drive);
  endproperty
  a_float_strapped: assert property (p_float_strapped)
    else $error("strapped phase not floating");

  property p_drive_unstrapped;
    @(posedge core_clk) disable iff (!rstn)
    (st == ST_RUN && !strap_c) |-> (pins.phase_c_oe && !pins.phase_c_sink);
  endproperty
  a_drive_unstrapped: assert property (p_drive_unstrapped)
    else $error("unstrapped phase not driven");

  property p_period;
    @(posedge core_clk) disable iff (!rstn)
    (start[0] && seen_a) |->
      since_a == 8'(`MPSS_MCLK_CYC * (2 + 32'(!strap_c) + 32'(!strap_d)));
  endproperty
  a_period: assert property (p_period)
    else $error("phase period not master over count");

  property p_disable;
    @(posedge core_clk) disable iff (!rstn)
    (!enable) [*2] |-> (drv == 4'h0 && !power_good_out && st == ST_OFF);
  endproperty
  a_disable: assert property (p_disable)
    else $error("enable low left outputs active");

  c_run: cover property (@(posedge core_clk) disable iff (!rstn)
    st == ST_RUN && power_good_out);
  c_three: cover property (@(posedge core_clk) disable iff (!rstn)
    st == ST_RUN && strap_d && !strap_c);
  c_two: cover property (@(posedge core_clk) disable iff (!rstn)
    st == ST_RUN && strap_d && strap_c);
  c_overlap: cover property (@(posedge core_clk) disable iff (!rstn)
    drv[0] && drv[1]);

endmodule

/* File: tb/mpss_gate_driver_model.sv */
`timescale 1ns/1ns
// far side: gate-driver inputs on phases c and d, plus board straps
module mpss_gate_driver_model
  import mpss_pkg::*;
(
  input  wire logic       core_clk,
  input  wire mpss_pins_t pins,
  input  wire logic       strap_c,
  input  wire logic       strap_d,
  output logic            phase_c_sense,
  output logic            phase_d_sense
);
  logic last_c = 1'b0;  // last resolved level of pin c
  logic last_d = 1'b0;  // last resolved level of pin d
  logic lvl_c;          // resolved level of pin c
  logic lvl_d;          // resolved level of pin d

  // a strap to supply wins, then the block's driver, then the weak sink;
  // a pin nobody holds shows the inverse of its last level, so a design
  // that forgets its pull-down cannot lean on a settled value
  always_comb begin
    lvl_c = strap_c ? 1'b1 : pins.phase_c_oe ? pins.phase_c_drive :
            pins.phase_c_sink ? 1'b0 : ~last_c;
    lvl_d = strap_d ? 1'b1 : pins.phase_d_oe ? pins.phase_d_drive :
            pins.phase_d_sink ? 1'b0 : ~last_d;
  end

  // remember levels for the floating case
  always_ff @(posedge core_clk) begin
    last_c <= lvl_c;
    last_d <= lvl_d;
  end

  // comparator view: high only when the pin sits at supply
  assign phase_c_sense = lvl_c;
  assign phase_d_sense = lvl_d;
endmodule

/* File: tb/multiphase_pwm_startup_sequencer_bench.sv */
`timescale 1ns/1ns
module multiphase_pwm_startup_sequencer_bench
  import mpss_pkg::*;
;
  logic               core_clk;
  logic               rstn;
  logic               enable;
  logic               supply_undervoltage_lockout;
  logic [5:0]         vid_code;
  mpss_ontime_t [3:0] ontime;
  logic               phase_c_sense;
  logic               phase_d_sense;
  mpss_pins_t         pins;
  logic               power_good_out;
  logic [5:0]         ss_ramp_level;
  logic               strap_c;      // board strap of pin c to supply
  logic               strap_d;      // board strap of pin d to supply
  int                 fail_count;   // mismatches seen
  int                 comparisons;  // compares made
  wire logic [3:0]    drv;          // drives, bit 0 is phase a

  assign drv = {pins.phase_d_drive, pins.phase_c_drive,
                pins.phase_b_drive, pins.phase_a_drive};

  mpss_top u_mpss_top (
    .core_clk                    (core_clk),
    .rstn                        (rstn),
    .enable                      (enable),
    .supply_undervoltage_lockout (supply_undervoltage_lockout),
    .vid_code                    (vid_code),
    .ontime                      (ontime),
    .phase_c_sense               (phase_c_sense),
    .phase_d_sense               (phase_d_sense),
    .pins                        (pins),
    .power_good_out              (power_good_out),
    .ss_ramp_level               (ss_ramp_level)
  );

  mpss_gate_driver_model u_mpss_gate_driver_model (
    .core_clk      (core_clk),
    .pins          (pins),
    .strap_c       (strap_c),
    .strap_d       (strap_d),
    .phase_c_sense (phase_c_sense),
    .phase_d_sense (phase_d_sense)
  );

  // 20 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // one-bit level compare
  task automatic chk_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  // cycle count compare, exact or within a window
  task automatic chk_cnt(input logic [15:0] got, input logic [15:0] lo,
                         input logic [15:0] hi);
    comparisons++;
    if (got < lo || got > hi) begin
      fail_count++;
      $display("FAIL t=%0t got=%0h exp=%0h", $time, got, lo);
    end
  endtask

  // cycles until drive i rises, bounded so a dead phase cannot hang
  task automatic wait_rise(input int i, output logic [15:0] n);
    logic p;
    logic r;
    p = drv[i];
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
      r = (p !== 1'b1) && (drv[i] === 1'b1);
      p = drv[i];
    end while (!r && n < 400);
  endtask

  // full start-up; delay 2000, detect 80, ramp 3x100, mask 1000, blank 2000
  task automatic startup(input logic sc, input logic sd, input int per);
    logic [15:0] n;
    strap_c = sc;
    strap_d = sd;
    enable = 1'b1;
    repeat (10) @(negedge core_clk);
    chk_bit(pins.phase_c_sink & pins.phase_d_sink, 1'b1);
    chk_bit(|drv, 1'b0);
    repeat (2050) @(negedge core_clk);
    chk_bit(drv[0] | drv[1], 1'b0);
    chk_bit(|drv, 1'b0);
    n = 2060;
    while (power_good_out !== 1'b1 && n < 9000) begin
      @(negedge core_clk);
      n++;
    end
    chk_cnt(n, 16'd5380, 16'd5410);
    chk_bit(ss_ramp_level === vid_code, 1'b1);
    chk_bit(pins.phase_c_oe, ~sc);
    chk_bit(pins.phase_d_oe, ~sd);
    chk_bit(pins.phase_c_sink | pins.phase_d_sink, 1'b0);
    wait_rise(0, n);
    wait_rise(0, n);
    chk_cnt(n, per[15:0], per[15:0]);
    wait_rise(1, n);
    chk_cnt(n, 16'd20, 16'd20);
  endtask

  // four phases: overlap of b and c, d held fully on
  task automatic test_four;
    logic [15:0] n;
    logic [15:0] k;
    startup(1'b0, 1'b0, 80);
    wait_rise(2, n);
    chk_cnt(n, 16'd20, 16'd20);
    repeat (2) @(negedge core_clk);
    chk_bit(drv[1] & drv[2], 1'b1);
    k = 0;
    repeat (100) begin
      @(negedge core_clk);
      if (drv[3] === 1'b1) k++;
    end
    chk_cnt(k, 16'd100, 16'd100);
    $display("test four-phase done at %0t", $time);
  endtask

  // strap d: a, b, c rotate and d never drives
  task automatic test_three;
    logic [15:0] n;
    startup(1'b0, 1'b1, 60);
    wait_rise(2, n);
    chk_cnt(n, 16'd20, 16'd20);
    wait_rise(0, n);
    chk_cnt(n, 16'd20, 16'd20);
    chk_bit(drv[3], 1'b0);
    $display("test three-phase done at %0t", $time);
  endtask

  // strap c and d: a and b alternate
  task automatic test_two;
    logic [15:0] n;
    startup(1'b1, 1'b1, 40);
    wait_rise(0, n);
    chk_cnt(n, 16'd20, 16'd20);
    chk_bit(drv[2] | drv[3], 1'b0);
    $display("test two-phase done at %0t", $time);
  endtask

  // stop by enable or by lockout; lockout must also hold off a restart
  task automatic test_drop(input logic by_lock);
    if (by_lock) supply_undervoltage_lockout = 1'b1;
    else enable = 1'b0;
    repeat (3) @(negedge core_clk);
    chk_bit(power_good_out, 1'b0);
    chk_bit(|drv, 1'b0);
    enable = 1'b1;
    supply_undervoltage_lockout = 1'b1;
    repeat (100) @(negedge core_clk);
    chk_bit(ss_ramp_level === 6'h00, 1'b1);
    chk_bit(pins.phase_c_sink & pins.phase_d_sink, 1'b1);
    enable = 1'b0;
    supply_undervoltage_lockout = 1'b0;
    @(negedge core_clk);
    $display("test drop done at %0t", $time);
  endtask

  // verdict and end of run
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // main sequence, inputs move on the falling edge
  initial begin
    fail_count = 0;
    comparisons = 0;
    rstn = 1'b0;
    enable = 1'b0;
    supply_undervoltage_lockout = 1'b0;
    vid_code = 6'h03;
    ontime = {8'hff, 8'h14, 8'h1e, 8'h0a};
    strap_c = 1'b0;
    strap_d = 1'b0;
    repeat (16) @(negedge core_clk);
    rstn = 1'b1;
    @(negedge core_clk);
    test_four;
    test_drop(1'b0);
    test_three;
    test_drop(1'b1);
    test_two;
    summarize;
  end

  // watchdog: three start-ups take under 18000 cycles
  initial begin
    repeat (40000) @(posedge core_clk);
    fail_count++;
    $display("watchdog expired at %0t", $time);
    summarize;
  end
endmodule
